// ==== src/atsd_regs.v ====
// Trim, core-swap timing and dither register bank with swap sequencer
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "atsd_regs_consts.vh"

module atsd_regs #(
  parameter ADDR_W = 12
) (
  input wire clk,
  input wire resetn,
  input wire [3:0] factoryBgTrim,
  input wire [31:0] factoryTermTrim,
  input wire swapRequest,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [3:0] bandgapTrim,
  output wire [31:0] terminationTrim,
  output wire ditherEnable,
  output wire ditherAmplitudeSelect,
  output wire roundingErrorSelect,
  output wire swapActive,
  output wire overlapActive,
  output wire steeringSelect
);

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_OVERLAP = 3'b010;
  localparam [2:0] ST_STEER = 3'b100;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [3:0] bgTrim_r;
  reg [7:0] termTrim_r [0:3];
  reg [4:0] overlapDelay_r;
  reg [4:0] steerDelay_r;
  reg [2:0] dither_r;
  reg factoryLoad_r;

  // Swap sequencer
  reg [2:0] state_r;
  reg [6:0] count_r;
  reg [4:0] latchedSteer_r;
  reg steerSel_r;

  // Bus state
  reg [ADDR_W-1:0] awAddr_r;
  reg awHeld_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg wHeld_r;
  reg bValid_r;
  reg [1:0] bResp_r;
  reg rValid_r;
  reg [31:0] rData_r;
  reg [1:0] rResp_r;

  // Word index decode; low two address bits are ignored
  function [7:0] regIndex;
    input [ADDR_W-1:0] addr;
    begin
      regIndex = addr[9:2];
    end
  endfunction

  function isMapped;
    input [7:0] idx;
    begin
      case (idx)
        `ATSD_IDX_BANDGAP, `ATSD_IDX_TERM_A, `ATSD_IDX_TERM_B,
        `ATSD_IDX_TERM_C, `ATSD_IDX_TERM_D, `ATSD_IDX_OVERLAP,
        `ATSD_IDX_STEER, `ATSD_IDX_DITHER, `ATSD_IDX_STATUS: begin
          isMapped = 1'b1;
        end
        default: begin
          isMapped = 1'b0;
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = ~awHeld_r & ~bValid_r;
  assign s_axi_wready = ~wHeld_r & ~bValid_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  wire doWrite = awHeld_r & wHeld_r & ~bValid_r;
  wire [7:0] wIdx = regIndex(awAddr_r);
  // Only byte lane 0 carries data; wider lanes read back as zero
  wire lane0 = wStrb_r[0];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awAddr_r <= {ADDR_W{1'b0}};
      awHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      wHeld_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= `ATSD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= (isMapped(wIdx) && wIdx != `ATSD_IDX_STATUS) ?
          `ATSD_RESP_OKAY : `ATSD_RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Factory values are caught one cycle after reset release, since an
  // asynchronous reset may only load constants.
  integer i;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      factoryLoad_r <= 1'b1;
      bgTrim_r <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        termTrim_r[i] <= 8'h00;
      end
      overlapDelay_r <= `ATSD_OVERLAP_RST;
      steerDelay_r <= `ATSD_STEER_RST;
      dither_r <= 3'h0;
    end else if (factoryLoad_r) begin
      factoryLoad_r <= 1'b0;
      bgTrim_r <= factoryBgTrim;
      for (i = 0; i < 4; i = i + 1) begin
        termTrim_r[i] <= factoryTermTrim[i*8 +: 8];
      end
    end else if (doWrite && lane0) begin
      // Reserved bits are dropped; host keeps them at zero
      case (wIdx)
        `ATSD_IDX_BANDGAP: begin
          bgTrim_r <= wData_r[`ATSD_BG_MSB:0];
        end
        `ATSD_IDX_TERM_A: begin
          termTrim_r[0] <= wData_r[7:0];
        end
        `ATSD_IDX_TERM_B: begin
          termTrim_r[1] <= wData_r[7:0];
        end
        `ATSD_IDX_TERM_C: begin
          termTrim_r[2] <= wData_r[7:0];
        end
        `ATSD_IDX_TERM_D: begin
          termTrim_r[3] <= wData_r[7:0];
        end
        `ATSD_IDX_OVERLAP: begin
          overlapDelay_r <= wData_r[`ATSD_DLY_MSB:0];
        end
        `ATSD_IDX_STEER: begin
          steerDelay_r <= wData_r[`ATSD_DLY_MSB:0];
        end
        `ATSD_IDX_DITHER: begin
          dither_r <= wData_r[`ATSD_DITH_MSB:0];
        end
        default: begin
          bgTrim_r <= bgTrim_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Background swap sequencer
  // ----------------------------------------------------------------
  // overlap length from delay
  wire [6:0] overlapLen = `ATSD_OVERLAP_BASE + {1'b0, overlapDelay_r, 1'b0};

  // Steering flips in overlap only when delay is inside the window
  reg [6:0] overlapLenL_r;
  // Compared at full width so a long overlap never flips twice
  wire steerLate = ({2'b00, latchedSteer_r} >= overlapLenL_r);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overlapLenL_r <= 7'h00;
    end else if (state_r == ST_IDLE && swapRequest) begin
      overlapLenL_r <= overlapLen;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      count_r <= 7'h00;
      latchedSteer_r <= `ATSD_STEER_RST;
      steerSel_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (swapRequest) begin
            count_r <= overlapLen - 7'h01;
            latchedSteer_r <= steerDelay_r;
            state_r <= ST_OVERLAP;
          end
        end
        ST_OVERLAP: begin
          if (count_r[4:0] == latchedSteer_r && count_r[6:5] == 2'h0) begin
            steerSel_r <= ~steerSel_r;
          end
          if (count_r == 7'h00) begin
            state_r <= ST_STEER;
          end else begin
            count_r <= count_r - 7'h01;
          end
        end
        ST_STEER: begin
          // Delay beyond the overlap still flips the select once
          if (count_r[4:0] == 5'h00 && steerLate) begin
            steerSel_r <= ~steerSel_r;
          end
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign swapActive = (state_r != ST_IDLE);
  assign overlapActive = (state_r == ST_OVERLAP);
  assign steeringSelect = steerSel_r;

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  wire [7:0] rIdx = regIndex(s_axi_araddr);
  reg [31:0] readMux;
  always @* begin
    readMux = 32'h00000000;
    case (rIdx)
      `ATSD_IDX_BANDGAP: readMux = {28'h0000000, bgTrim_r};
      `ATSD_IDX_TERM_A: readMux = {24'h000000, termTrim_r[0]};
      `ATSD_IDX_TERM_B: readMux = {24'h000000, termTrim_r[1]};
      `ATSD_IDX_TERM_C: readMux = {24'h000000, termTrim_r[2]};
      `ATSD_IDX_TERM_D: readMux = {24'h000000, termTrim_r[3]};
      `ATSD_IDX_OVERLAP: readMux = {27'h0000000, overlapDelay_r};
      `ATSD_IDX_STEER: readMux = {27'h0000000, steerDelay_r};
      `ATSD_IDX_DITHER: readMux = {29'h00000000, dither_r};
      `ATSD_IDX_STATUS: readMux = {29'h00000000, steerSel_r,
        overlapActive, swapActive};
      default: readMux = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= `ATSD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rData_r <= readMux;
      rResp_r <= isMapped(rIdx) ? `ATSD_RESP_OKAY : `ATSD_RESP_SLVERR;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the analog and dither logic
  // ----------------------------------------------------------------
  assign bandgapTrim = bgTrim_r;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gTerm
      assign terminationTrim[g*8 +: 8] = termTrim_r[g];
    end
  endgenerate
  assign ditherEnable = dither_r[`ATSD_DITH_EN_BIT];
  assign ditherAmplitudeSelect = dither_r[`ATSD_DITH_AMP_BIT];
  assign roundingErrorSelect = dither_r[`ATSD_DITH_ERR_BIT];

endmodule
`default_nettype wire

// ==== inc/atsd_regs_consts.vh ====
// Constants for the converter trim, swap and dither register bank
`ifndef ATSD_REGS_CONSTS_VH
`define ATSD_REGS_CONSTS_VH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ATSD_IDX_BANDGAP 8'h7C
`define ATSD_IDX_TERM_A 8'h7E
`define ATSD_IDX_TERM_B 8'h7F
`define ATSD_IDX_TERM_C 8'h80
`define ATSD_IDX_TERM_D 8'h81
`define ATSD_IDX_OVERLAP 8'h9A
`define ATSD_IDX_STEER 8'h9B
`define ATSD_IDX_DITHER 8'h9D
`define ATSD_IDX_STATUS 8'hA0
// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define ATSD_BG_MSB 3
`define ATSD_DLY_MSB 4
`define ATSD_DLY_W 5
`define ATSD_DITH_EN_BIT 0
`define ATSD_DITH_AMP_BIT 1
`define ATSD_DITH_ERR_BIT 2
`define ATSD_DITH_MSB 2
`define ATSD_OVERLAP_RST 5'h08
`define ATSD_STEER_RST 5'h07
`define ATSD_OVERLAP_BASE 7'h04
`define ATSD_RESP_OKAY 2'h0
`define ATSD_RESP_SLVERR 2'h2
`endif

// ==== tb/atsd_regs_sva.sv ====
// Port-level checks for the trim, swap and dither register bank
`timescale 1ns/10ps
`default_nettype none
module atsd_regs_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic swapRequest,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] bandgapTrim,
  input wire logic ditherEnable,
  input wire logic swapActive,
  input wire logic overlapActive,
  input wire logic steeringSelect
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  // Factory load on the first edge after reset is the only other source
  property p_bg_by_write;
    $changed(bandgapTrim) |-> $rose(s_axi_bvalid) || !$past(resetn, 2);
  endproperty
  a_bg_by_write: assert property (p_bg_by_write) else $error("trim moved");
  property p_dith_by_write;
    $changed(ditherEnable) |-> $rose(s_axi_bvalid) || !$past(resetn);
  endproperty
  a_dith_by_write: assert property (p_dith_by_write) else $error("dither moved");
  property p_swap_start;
    swapRequest && !swapActive |=> overlapActive;
  endproperty
  a_swap_start: assert property (p_swap_start) else $error("swap not begun");
  property p_ovl_min;
    $rose(overlapActive) |-> overlapActive [*4];
  endproperty
  a_ovl_min: assert property (p_ovl_min) else $error("overlap too short");
  property p_swap_bound;
    $rose(swapActive) |-> ##[5:67] !swapActive;
  endproperty
  a_swap_bound: assert property (p_swap_bound) else $error("swap too long");
  property p_ovl_in_swap;
    overlapActive |-> swapActive;
  endproperty
  a_ovl_in_swap: assert property (p_ovl_in_swap) else $error("stray overlap");
  property p_steer_in_swap;
    $changed(steeringSelect) |-> $past(swapActive);
  endproperty
  a_steer_in_swap: assert property (p_steer_in_swap) else $error("stray select");
endmodule
bind atsd_regs atsd_regs_sva u_sva (.clk(clk), .resetn(resetn),
  .swapRequest(swapRequest), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .bandgapTrim(bandgapTrim),
  .ditherEnable(ditherEnable), .swapActive(swapActive),
  .overlapActive(overlapActive), .steeringSelect(steeringSelect));
`default_nettype wire

// ==== tb/adc_trim_swap_dither_regs_tb_top.sv ====
// Self-checking bench for the trim, swap and dither register bank
`timescale 1ns/10ps
`default_nettype none
`include "atsd_regs_consts.vh"
module adc_trim_swap_dither_regs_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] fBg = 4'h0;
  logic [31:0] fTerm = 32'h0;
  logic swapRequest = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, terminationTrim;
  wire [3:0] bandgapTrim;
  wire ditherEnable, ditherAmplitudeSelect, roundingErrorSelect;
  wire swapActive, overlapActive, steeringSelect;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [7:0] regIdx [8] = '{`ATSD_IDX_BANDGAP, `ATSD_IDX_TERM_A,
    `ATSD_IDX_TERM_B, `ATSD_IDX_TERM_C, `ATSD_IDX_TERM_D,
    `ATSD_IDX_OVERLAP, `ATSD_IDX_STEER, `ATSD_IDX_DITHER};
  logic [31:0] shadow [8];
  atsd_regs uut (.clk(clk), .resetn(resetn), .factoryBgTrim(fBg),
    .factoryTermTrim(fTerm), .swapRequest(swapRequest),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .bandgapTrim(bandgapTrim),
    .terminationTrim(terminationTrim), .ditherEnable(ditherEnable),
    .ditherAmplitudeSelect(ditherAmplitudeSelect),
    .roundingErrorSelect(roundingErrorSelect), .swapActive(swapActive),
    .overlapActive(overlapActive), .steeringSelect(steeringSelect));
  always #2 clk = ~clk;
  // ------------------------------------------------------------
  // Checking and expectations
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] fieldMask(input logic [7:0] idx);
    case (idx)
      `ATSD_IDX_BANDGAP: fieldMask = 32'h0000000F;
      `ATSD_IDX_OVERLAP, `ATSD_IDX_STEER: fieldMask = 32'h0000001F;
      `ATSD_IDX_DITHER: fieldMask = 32'h00000007;
      default: fieldMask = 32'h000000FF;
    endcase
  endfunction
  function automatic logic [31:0] resetVal(input int i);
    case (i)
      0: resetVal = {28'h0, fBg};
      5: resetVal = {27'h0, `ATSD_OVERLAP_RST};
      6: resetVal = {27'h0, `ATSD_STEER_RST};
      7: resetVal = 32'h0;
      default: resetVal = {24'h0, fTerm[8*(i-1) +: 8]};
    endcase
  endfunction
  // ------------------------------------------------------------
  // Bus tasks: readies are sampled half a cycle early, since they
  // only move on rising edges
  // ------------------------------------------------------------
  task automatic axiWrite(input logic [7:0] idx, input logic [31:0] d,
      output logic [1:0] r);
    logic aw, w, b, ta, tw;
    {aw, w, b} = 3'h6;
    @(posedge clk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      {ta, tw, b} = {aw & s_axi_awready, w & s_axi_wready, s_axi_bvalid};
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      {aw, w} = {aw & !ta, w & !tw};
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic readExp(input logic [7:0] idx, input logic [31:0] e,
      input logic [1:0] er);
    logic a, b, ta;
    logic [31:0] d;
    logic [1:0] r;
    {a, b} = 2'h2;
    @(posedge clk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      {ta, b, d, r} = {a & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      a = a & !ta;
    end
    s_axi_rready <= 1'b0;
    check("rdata", d, e);
    check("rresp", {30'h0, r}, {30'h0, er});
  endtask
  // Counts overlap cycles while the overlap delay is rewritten mid-swap
  task automatic swapRun(input logic [4:0] cur, input logic [4:0] nxt);
    int n;
    logic s0;
    logic [1:0] r;
    {n, s0} = {32'h0, steeringSelect};
    @(posedge clk);
    swapRequest <= 1'b1;
    @(posedge clk);
    swapRequest <= 1'b0;
    fork
      repeat (72) begin
        #1;
        n = n + (overlapActive === 1'b1);
        @(posedge clk);
      end
      axiWrite(`ATSD_IDX_OVERLAP, {27'h0, nxt}, r);
    join
    check("overlap cycles", n, 4 + 2 * cur);
    check("steeringSelect", {31'h0, steeringSelect}, {31'h0, !s0});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [4:0] seq [6];
    void'($urandom(32'h7B79A68D));
    fBg <= 4'($urandom);
    fTerm <= $urandom;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++) readExp(regIdx[i], resetVal(i), 2'h0);
    // reserved bits always written as zero
    repeat (4) begin
      for (int i = 0; i < 8; i++) begin
        v = $urandom & fieldMask(regIdx[i]);
        shadow[i] = v;
        axiWrite(regIdx[i], v, r);
        check("bresp", {30'h0, r}, 32'h0);
        readExp(regIdx[i], v, `ATSD_RESP_OKAY);
      end
      check("bandgapTrim", {28'h0, bandgapTrim}, shadow[0]);
      check("terminationTrim", terminationTrim, {shadow[4][7:0],
        shadow[3][7:0], shadow[2][7:0], shadow[1][7:0]});
    end
    for (int k = 0; k < 8; k++) begin
      axiWrite(`ATSD_IDX_DITHER, 32'(k), r);
      check("dither", {29'h0, roundingErrorSelect, ditherAmplitudeSelect,
        ditherEnable}, 32'(k));
    end
    readExp(8'hB0, 32'h0, `ATSD_RESP_SLVERR);
    axiWrite(`ATSD_IDX_STATUS, 32'h7, r);
    check("bresp", {30'h0, r}, {30'h0, `ATSD_RESP_SLVERR});
    seq = '{5'h08, 5'h00, 5'h1F, 5'($urandom), 5'h07, 5'h08};
    readExp(`ATSD_IDX_STATUS, 32'h0, `ATSD_RESP_OKAY);
    axiWrite(`ATSD_IDX_STEER, 32'h0000001F, r);
    check("bresp", {30'h0, r}, 32'h0);
    axiWrite(`ATSD_IDX_OVERLAP, {27'h0, seq[0]}, r);
    for (int j = 0; j < 5; j++) swapRun(seq[j], seq[j+1]);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
